/* File: rtl/dma_channel_ctl.sv */
// Overview of operation
// - Completed transfer clears channel enable by itself.
// - Suspend stops all source reads.
// - Suspended empty flag ignores sub-word residue.
// - Residue below one destination word is not written out while suspended.
// - Resume bit ends suspension, transfer continues.
// - Disabled channel issues no further acknowledges.
// - Disable is a request; status clears after beat.
// - Global enable clear stops every channel.
// - FIFO data is dropped on disable.
// - Opposite side waits for flow controller last.
// - Destination flow control may drop width residue.
// - Memory source prefetches under destination flow control.
// - Zero size under controller flow disables channel.
// - Auto mode under controller flow reloads size from previous value.
// - Write protection blocks guarded writes, records source.
// - Correct key write clears violation flag.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dma_channel_ctl (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [9:0] awaddr,
  input wire logic awvalid,
  output var logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output var logic wready,
  output var logic [1:0] bresp,
  output var logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  output var logic arready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  output var logic rvalid,
  input wire logic rready,
  // Peripheral handshake.
  input wire dma_ctl_pkg::periph_s periph,
  output wire dma_ctl_pkg::ack_s ack
);
  import dma_ctl_pkg::*;

  periph_s sync1, sync2;
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [9:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_data, cmd;
  logic [31:0] gcfg, next_gcfg;
  logic glob_en, next_glob_en, write_protect_enable, next_write_protect_enable, write_violation_flag, next_write_violation_flag;
  logic [7:0] violation_source_field, next_violation_source_field;
  logic wr_do, wr_prot;
  dec_s wdc, rdc;
  logic [NCH-1:0] ena_v, susp_v, empt_v;
  logic [31:0] rd_word [NCH];

  function automatic dec_s decode(input logic [9:0] a);
    logic [9:0] rel;
    decode = '0;
    rel = a - OFS_CH_BASE;
    if (a >= OFS_CH_BASE && a < OFS_WPMR && a[1:0] == 2'h0) begin
      decode.ch = 3'(rel / CH_STRIDE);
      decode.slot = 4'((rel % CH_STRIDE) >> 2);
      decode.hit = (decode.slot < 4'h8) && (rel < CH_STRIDE * 10'(NCH)); // No alias above ch 7.
    end
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      lanes[8*b +: 8] = {8{s[b]}};
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
    merge = (o & ~lanes(s)) | (d & lanes(s));
  endfunction

  // Handshake pins come from other clock domains, so two stages first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= periph;
      sync2 <= sync1;
    end
  end

  // A write is carried out once address and data are both held.
  assign wr_do = aw_held && w_held && !bvalid;
  assign wdc = decode(aw_addr);
  assign rdc = decode(araddr);
  assign cmd = w_data & lanes(w_strb);
  assign wr_prot = write_protect_enable && (aw_addr == OFS_GCFG || aw_addr == OFS_EN || wdc.hit);

  // Read data mux; reserved and write-only locations read as zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rdc.hit) begin
      rd_data = rd_word[rdc.ch];
    end else begin
      unique case (araddr)
        OFS_GCFG: rd_data = gcfg;
        OFS_EN: rd_data = {31'h0, glob_en};
        OFS_CHSR: rd_data = {8'h00, empt_v, susp_v, ena_v};
        OFS_WPMR: rd_data = {31'h0, write_protect_enable};
        OFS_WPSR: rd_data = {16'h0, violation_source_field, 7'h0, write_violation_flag};
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Bus handshake next state; one write and one read in flight at most.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (wr_do) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr < MAP_END && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = (araddr < MAP_END && araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 10'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready || (!arready && !rvalid);
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Global configuration, controller enable and write protection.
  always_comb begin
    next_gcfg = gcfg;
    next_glob_en = glob_en;
    next_write_protect_enable = write_protect_enable;
    next_write_violation_flag = write_violation_flag;
    next_violation_source_field = violation_source_field;
    if (wr_do) begin
      if (wr_prot) begin
        next_write_violation_flag = 1'b1;
        next_violation_source_field = aw_addr[9:2];
      end else if (aw_addr == OFS_GCFG) begin
        next_gcfg = merge(gcfg, w_data, w_strb);
      end else if (aw_addr == OFS_EN && w_strb[0]) begin
        next_glob_en = w_data[0];
      end
      if (aw_addr == OFS_WPMR && w_data[PROTECT_ACCESS_KEY_LSB +: 24] == WP_KEY && w_strb == 4'hF) begin
        next_write_protect_enable = w_data[0];
        next_write_violation_flag = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gcfg <= GCFG_RST;
      glob_en <= 1'b0;
      write_protect_enable <= 1'b0;
      write_violation_flag <= 1'b0;
      violation_source_field <= 8'h00;
    end else begin
      gcfg <= next_gcfg;
      glob_en <= next_glob_en;
      write_protect_enable <= next_write_protect_enable;
      write_violation_flag <= next_write_violation_flag;
      violation_source_field <= next_violation_source_field;
    end
  end

  // One channel engine per channel; the FIFO is modelled by its byte count.
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    chan_s st, nx;
    logic [31:0] creg [NREG];
    logic [31:0] next_creg [NREG];
    logic [4:0] sb, db;
    logic [15:0] buffer_transfer_size;
    flow_e fc;
    logic smem, auto_on, fc_last, src_ok, dst_ok, busy, done, reg_wr;

    assign buffer_transfer_size = creg[SLOT_CTRLA[2:0]][BUFFER_TRANSFER_SIZE_LSB +: 16];
    assign sb = 5'h01 << creg[SLOT_CTRLA[2:0]][SRC_W_LSB +: 2];
    assign db = 5'h01 << creg[SLOT_CTRLA[2:0]][DST_W_LSB +: 2];
    assign fc = flow_e'(creg[SLOT_CTRLB[2:0]][FC_LSB +: 2]);
    assign smem = creg[SLOT_CTRLB[2:0]][SRC_MEM_BIT];
    assign auto_on = creg[SLOT_CTRLB[2:0]][AUTO_BIT];
    assign reg_wr = wr_do && !wr_prot && wdc.hit && wdc.ch == 3'(c);
    assign busy = st.sack || st.dack;
    // No new source beat once a stop is pending or the flow controller's last is in.
    assign src_ok = st.ena && !st.stop && !st.susp && !st.sack && !st.last_seen
      && (st.fifo + sb <= FIFO_BYTES)
      && (smem || sync2.src_req[c])
      && !(fc == FC_DST && !smem && !(sync2.dst_last[c] || st.last_seen))
      && !(fc == FC_CTRL && st.remain == 16'h0000);
    assign dst_ok = st.ena && !st.stop && !st.dack && sync2.dst_req[c] && st.fifo >= db
      && !(fc == FC_SRC && !(sync2.src_last[c] || st.last_seen));
    assign fc_last = (fc == FC_SRC && src_ok && sync2.src_last[c])
      || (fc == FC_DST && dst_ok && sync2.dst_last[c]);
    // Under peripheral flow a residue below one destination word ends the job.
    assign done = !busy && st.fifo < db
      && (fc == FC_CTRL ? st.remain == 16'h0000 : st.last_seen);
    assign ena_v[c] = st.ena;
    assign susp_v[c] = st.susp;
    // While suspended a sub-word residue already counts as empty.
    assign empt_v[c] = st.susp ? (st.fifo < db) : (st.fifo == 5'h00);
    assign rd_word[c] = (rdc.slot < 4'h8) ? creg[rdc.slot[2:0]] : 32'h0000_0000;
    assign ack.src_ack[c] = st.sack;
    assign ack.dst_ack[c] = st.dack;

    always_comb begin
      nx = st;
      for (int k = 0; k < NREG; k++) begin
        next_creg[k] = (reg_wr && wdc.slot == 4'(k)) ? merge(creg[k], w_data, w_strb) : creg[k];
      end
      nx.sack = src_ok && !smem;
      nx.dack = dst_ok;
      if (src_ok) begin
        nx.remain = st.remain - 16'h0001;
      end
      nx.fifo = st.fifo + (src_ok ? sb : 5'h00) - (dst_ok ? db : 5'h00);
      if (fc_last) begin
        nx.last_seen = 1'b1;
      end
      if (wr_do && aw_addr == OFS_CHER && cmd[SUSP_LSB + c]) begin
        nx.susp = 1'b1;
      end else if (wr_do && aw_addr == OFS_CHER && cmd[RES_LSB + c]) begin
        nx.susp = 1'b0;
      end
      if (st.ena && (!glob_en || (wr_do && aw_addr == OFS_CHDR && cmd[c]))) begin
        nx.stop = 1'b1;
      end
      if (!st.ena) begin
        if (wr_do && aw_addr == OFS_CHER && cmd[c] && glob_en) begin
          nx.ena = 1'b1;
          nx.stop = 1'b0;
          nx.last_seen = 1'b0;
          nx.fifo = 5'h00;
          nx.remain = buffer_transfer_size;
        end
      end else if (st.stop && !busy) begin
        // The last beat has closed, so the request now takes effect.
        nx.ena = 1'b0;
        nx.fifo = 5'h00;
        nx.stop = 1'b0;
      end else if (done) begin
        if (auto_on && fc == FC_CTRL && buffer_transfer_size != 16'h0000) begin
          nx.remain = buffer_transfer_size;
        end else begin
          nx.ena = 1'b0;
          nx.fifo = 5'h00;
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        st <= '0;
        for (int k = 0; k < NREG; k++) begin
          creg[k] <= 32'h0000_0000;
        end
      end else begin
        st <= nx;
        creg <= next_creg;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dma_ctl_pkg.sv */
package dma_ctl_pkg;
  localparam int NCH = 8;
  localparam int NREG = 8;
  // Byte offsets of the register map.
  localparam logic [9:0] OFS_GCFG = 10'h000;
  localparam logic [9:0] OFS_EN = 10'h004;
  localparam logic [9:0] OFS_CHER = 10'h028;
  localparam logic [9:0] OFS_CHDR = 10'h02C;
  localparam logic [9:0] OFS_CHSR = 10'h030;
  localparam logic [9:0] OFS_CH_BASE = 10'h03C;
  localparam logic [9:0] CH_STRIDE = 10'h028;
  localparam logic [9:0] OFS_WPMR = 10'h1E4;
  localparam logic [9:0] OFS_WPSR = 10'h1E8;
  localparam logic [9:0] MAP_END = 10'h200;
  // Channel register slots inside one channel block.
  localparam logic [3:0] SLOT_CTRLA = 4'h3;
  localparam logic [3:0] SLOT_CTRLB = 4'h4;
  // Values after reset.
  localparam logic [31:0] GCFG_RST = 32'h0000_0010;
  // Field positions.
  localparam int SUSP_LSB = 8;
  localparam int RES_LSB = 16;
  localparam int EMPT_LSB = 16;
  localparam int BUFFER_TRANSFER_SIZE_LSB = 0;
  localparam int SRC_W_LSB = 24;
  localparam int DST_W_LSB = 28;
  localparam int FC_LSB = 21;
  localparam int SRC_MEM_BIT = 29;
  localparam int AUTO_BIT = 31;
  localparam int PROTECT_ACCESS_KEY_LSB = 8;
  localparam int VIOLATION_SOURCE_FIELD_LSB = 8;
  // Channel FIFO capacity in bytes.
  localparam logic [4:0] FIFO_BYTES = 5'h10;
  // Access key for the protect register; the value is arbitrary.
  localparam logic [23:0] WP_KEY = 24'h5A3C96;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FC_CTRL = 2'h0,
    FC_SRC = 2'h1,
    FC_DST = 2'h2
  } flow_e;

  // Handshake pins from the peripherals, one bit per channel.
  typedef struct packed {
    logic [NCH-1:0] src_req;
    logic [NCH-1:0] dst_req;
    logic [NCH-1:0] src_last;
    logic [NCH-1:0] dst_last;
  } periph_s;

  typedef struct packed {
    logic [NCH-1:0] src_ack;
    logic [NCH-1:0] dst_ack;
  } ack_s;

  typedef struct packed {
    logic ena;
    logic susp;
    logic stop;
    logic last_seen;
    logic sack;
    logic dack;
    logic [4:0] fifo;
    logic [15:0] remain;
  } chan_s;

  typedef struct packed {
    logic hit;
    logic [2:0] ch;
    logic [3:0] slot;
  } dec_s;
endpackage

/* File: tb/dma_channel_ctl_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module dma_channel_ctl_chk (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic [9:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Peripheral handshake.
  input wire dma_ctl_pkg::periph_s periph,
  input wire dma_ctl_pkg::ack_s ack
);
  import dma_ctl_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Beats come at most every other cycle, and destination beats only for a recent request.
  AST_ACK_GAP: assert property (
    ((ack.src_ack & $past(ack.src_ack)) | (ack.dst_ack & $past(ack.dst_ack))) == '0)
    else $error("acknowledge pulses back to back");
  AST_DST_CAUSE: assert property (
    (ack.dst_ack & ~($past(periph.dst_req) | $past(periph.dst_req, 2)
    | $past(periph.dst_req, 3) | $past(periph.dst_req, 4))) == '0)
    else $error("destination acknowledge without request");
  // Register bus timing and error codes.
  AST_W_ANSWER: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:3] bvalid) else $error("no write answer");
  AST_W_BUSY: assert property (
    awvalid && awready && wvalid && wready |=> !awready && !wready) else $error("write overlap");
  AST_W_SLVERR: assert property (
    awvalid && awready && awaddr[1:0] != 2'h0 |-> ##[1:16] bvalid && bresp == RESP_SLVERR)
    else $error("misaligned write accepted");
  AST_R_ANSWER: assert property (
    arvalid && arready |=> rvalid && !arready) else $error("no read answer");
  AST_R_DONE: assert property (
    rvalid && rready |=> !rvalid && arready) else $error("read answer not retired");
  AST_R_SLVERR: assert property (
    arvalid && arready && (araddr >= MAP_END || araddr[1:0] != 2'h0)
    |=> rresp == RESP_SLVERR && rdata == 32'h0) else $error("bad read accepted");
endmodule
`default_nettype wire

/* File: tb/periph_model.sv */
`timescale 1ns/10ps
`default_nettype none
module periph_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bench switches, one bit per channel.
  input wire logic [dma_ctl_pkg::NCH-1:0] src_on,
  input wire logic [dma_ctl_pkg::NCH-1:0] dst_on,
  input wire logic [dma_ctl_pkg::NCH-1:0] last_on,
  // Handshake pins.
  input wire dma_ctl_pkg::ack_s ack,
  output var dma_ctl_pkg::periph_s periph
);
  import dma_ctl_pkg::*;
  initial periph = '0;
  // Each channel owns its pin pair, so no peripheral serves two channels.
  // Requests rise after a random wait, giving both prompt and slow peripherals.
  always @(posedge aclk) begin
    for (int c = 0; c < NCH; c++) begin
      if (!aresetn || ack.src_ack[c]) periph.src_req[c] <= 1'b0;
      else if (src_on[c] && $urandom_range(2) == 0) periph.src_req[c] <= 1'b1;
      if (!aresetn || ack.dst_ack[c]) periph.dst_req[c] <= 1'b0;
      else if (dst_on[c] && $urandom_range(2) == 0) periph.dst_req[c] <= 1'b1;
    end
    periph.src_last <= last_on;
    periph.dst_last <= last_on;
  end
endmodule
`default_nettype wire

/* File: tb/dma_channel_disable_and_protect_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module dma_channel_disable_and_protect_bench;
  import dma_ctl_pkg::*;
  // Bus, handshake and bench state.
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wr_resp, rd_resp;
  logic [NCH-1:0] src_on, dst_on, last_on;
  periph_s periph;
  ack_s ack;
  int n_mismatch, tests_run, k, ns[NCH], nd[NCH];

  dma_channel_ctl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .periph(periph), .ack(ack));
  periph_model far_end (.aclk(aclk), .aresetn(aresetn), .src_on(src_on), .dst_on(dst_on),
    .last_on(last_on), .ack(ack), .periph(periph));

  // Bus clock, 25 ns period.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Count acknowledge pulses per channel; each lasts one cycle.
  always @(posedge aclk) begin
    for (int c = 0; c < NCH; c++) begin
      if (ack.src_ack[c] === 1'b1) ns[c]++;
      if (ack.dst_ack[c] === 1'b1) nd[c]++;
    end
  end

  // A hung handshake must not stall the run.
  initial begin
    #(25 * 40000);
    n_mismatch++;
    tally_and_finish();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic axw(input logic [9:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && t < 200);
    wr_resp = bresp;
    bready <= 1'b0;
    if (t >= 200) n_mismatch++;
  endtask

  task automatic axr(input logic [9:0] a);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && t < 200);
    rd = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    if (t >= 200) n_mismatch++;
  endtask

  // Read until the masked bits settle, bounded, then compare.
  task automatic poll(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
    int i;
    i = 0;
    axr(a);
    while ((rd & m) !== e && i < 60) begin
      axr(a);
      i++;
    end
    check(rd & m, e);
  endtask

  function automatic logic [9:0] ca(input int c, input logic [3:0] s);
    return OFS_CH_BASE + 10'(c * CH_STRIDE) + {4'h0, s, 2'h0};
  endfunction

  // Channels are programmed only while disabled, then enabled.
  // Address registers keep their reset value of zero, aligned for every width.
  task automatic chan(input int c, input logic [31:0] ctl_a, input logic [31:0] ctl_b);
    axw(ca(c, SLOT_CTRLA), ctl_a);
    axw(ca(c, SLOT_CTRLB), ctl_b);
    axw(OFS_CHER, 32'h1 << c);
  endtask

  initial begin
    void'($urandom(55291));
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {src_on, dst_on, last_on} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, an unmapped read and a misaligned write.
    poll(OFS_GCFG, '1, GCFG_RST);
    poll(OFS_CHSR, '1, 32'h00FF0000);
    axr(MAP_END);
    check(32'(rd_resp), 32'(RESP_SLVERR));
    axw(10'h006, 32'h1);
    check(32'(wr_resp), 32'(RESP_SLVERR));
    axw(OFS_EN, 32'h1);
    chan(0, 32'h0, 32'h0);
    poll(OFS_CHSR, 32'h1, 32'h0);
    // Suspended before its peripherals start, then resumed to completion.
    k = $urandom_range(8, 3);
    chan(2, 32'(k), 32'h0);
    axw(OFS_CHER, 32'h1 << (SUSP_LSB + 2));
    src_on[2] <= 1'b1;
    dst_on[2] <= 1'b1;
    repeat (30) @(posedge aclk);
    check(32'(ns[2]), 32'h0);
    axw(OFS_CHER, 32'h1 << (RES_LSB + 2));
    poll(OFS_CHSR, 32'h4, 32'h0);
    check(32'(ns[2]), 32'(k));
    check(32'(nd[2]), 32'(k));
    // Auto reload keeps a short buffer running until software disables it.
    k = ns[2];
    chan(2, 32'h3, 32'h1 << AUTO_BIT);
    repeat (120) @(posedge aclk);
    check(32'(ns[2] - k > 6), 32'h1);
    axw(OFS_CHDR, 32'h4);
    poll(OFS_CHSR, 32'h4, 32'h0);
    // Bytes into words: suspend, drain whole words, disable and drop the residue.
    chan(3, 32'h2000_0028, 32'h0);
    src_on[3] <= 1'b1;
    repeat (20) @(posedge aclk);
    axw(OFS_CHER, 32'h1 << (SUSP_LSB + 3));
    repeat (8) @(posedge aclk);
    k = ns[3];
    dst_on[3] <= 1'b1;
    poll(OFS_CHSR, 32'h0008_0000, 32'h0008_0000);
    repeat (10) @(posedge aclk);
    check(32'(nd[3]), 32'(k / 4));
    check(32'(ns[3]), 32'(k));
    axw(OFS_CHDR, 32'h8);
    poll(OFS_CHSR, 32'h0008_0008, 32'h0008_0000);
    check(32'(nd[3]), 32'(k / 4));
    // Clearing the global enable stops busy channels.
    chan(4, 32'hC8, 32'h0);
    chan(5, 32'hC8, 32'h0);
    src_on[5:4] <= 2'h3;
    repeat (20) @(posedge aclk);
    axw(OFS_EN, 32'h0);
    poll(OFS_CHSR, 32'hFF, 32'h0);
    axw(OFS_EN, 32'h1);
    // Source peripheral owns the flow: destination waits for its last flag.
    chan(6, 32'h5, 32'(FC_SRC) << FC_LSB);
    src_on[6] <= 1'b1;
    dst_on[6] <= 1'b1;
    repeat (40) @(posedge aclk);
    check(32'(nd[6]), 32'h0);
    last_on[6] <= 1'b1;
    poll(OFS_CHSR, 32'h40, 32'h0);
    // Memory source under destination flow fills with no request at all.
    chan(7, 32'h8, (32'(FC_DST) << FC_LSB) | (32'h1 << SRC_MEM_BIT));
    repeat (20) @(posedge aclk);
    poll(OFS_CHSR, 32'h0080_0000, 32'h0);
    // Protected writes are blocked yet answered OKAY; the source is recorded.
    axw(OFS_WPMR, {WP_KEY, 8'h01});
    axw(OFS_EN, 32'h0);
    check(32'(wr_resp), 32'(RESP_OKAY));
    poll(OFS_EN, '1, 32'h1);
    poll(OFS_WPSR, '1, 32'h0000_0101);
    k = $urandom_range(1, 0);
    for (int s = 0; s < 8; s++) begin
      axw(ca(k, 4'(s)), $urandom);
      poll(ca(k, 4'(s)), '1, 32'h0);
      poll(OFS_WPSR, '1, {16'h0, 8'(ca(k, 4'(s)) >> 2), 8'h01});
    end
    axw(OFS_WPMR, {WP_KEY, 8'h00});
    poll(OFS_WPSR, '1, {16'h0, 8'(ca(k, 4'h7) >> 2), 8'h00});
    tally_and_finish();
  end
endmodule

bind dma_channel_ctl dma_channel_ctl_chk chk (.aclk(aclk), .aresetn(aresetn),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .periph(periph),
  .ack(ack));
`default_nettype wire
